// File: gsob_bank.sv
// Pin bank: two-way pins, switch gates, control outputs and flag register
`timescale 1ns/1ps
module gsob_bank #(
    parameter logic [gsob_pkg::DBNC_CNT_W-1:0] DBNC_STEP =
        gsob_pkg::DBNC_STEP_CYC
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire gsob_pkg::gsob_reg_req_s regReq,
    output gsob_pkg::gsob_reg_rsp_s regRsp,
    input wire logic [gsob_pkg::PIN_COUNT-1:0] pinIn,
    output logic [gsob_pkg::PIN_COUNT-1:0] pinOut,
    output logic [gsob_pkg::PIN_COUNT-1:0] pinOe,
    output logic [gsob_pkg::SW_COUNT-1:0] swOut,
    output logic [gsob_pkg::SW_COUNT-1:0] swOe,
    output logic [2*gsob_pkg::SW_COUNT-1:0] swSlew,
    output logic [gsob_pkg::CTRL_COUNT-1:0] ctrlOut,
    output logic summaryIrqSet
);
    import gsob_pkg::*;

    // ****************************************************************
    // Storage
    // ****************************************************************
    gsob_pin_ctrl_s pinCtrl_r [PIN_COUNT];
    gsob_sw_ctrl_s swCtrl_r [SW_COUNT];
    logic [CTRL_COUNT-1:0] ctrlVal_r;
    logic [PIN_COUNT-1:0] flags_r;
    logic [PIN_COUNT-1:0] flags_nxt;

    logic [PIN_COUNT-1:0] syncA_r;
    logic [PIN_COUNT-1:0] syncB_r;
    logic [PIN_COUNT-1:0] filtered;
    logic [PIN_COUNT-1:0] prevFilt_r;
    logic [PIN_COUNT-1:0] edgeSet;

    logic [PIN_COUNT-1:0] pinOut_r;
    logic [PIN_COUNT-1:0] pinOe_r;
    logic [SW_COUNT-1:0] swOut_r;
    logic [SW_COUNT-1:0] swOe_r;
    logic [2*SW_COUNT-1:0] swSlew_r;
    logic [CTRL_COUNT-1:0] ctrlOut_r;
    logic summary_r;
    logic [DATA_W-1:0] rdData_r;
    logic rdValid_r;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    logic hitFlags;
    logic hitCtrlOut;
    logic hitPin;
    logic hitSw;
    logic [2:0] pinIdx;
    logic [1:0] swIdx;
    logic [ADDR_W-1:0] pinOff;
    logic [ADDR_W-1:0] swOff;

    // Base check needed; the offset alone wraps below the base
    function automatic logic inWindow(logic [ADDR_W-1:0] addr,
                                      logic [ADDR_W-1:0] base,
                                      int count);
        logic [ADDR_W-1:0] off;
        off = addr - base;
        return (addr >= base) && (off < ADDR_W'(count));
    endfunction

    assign pinOff = regReq.addr - ADDR_PIN_BASE;
    assign swOff = regReq.addr - ADDR_SW_BASE;
    assign hitFlags = (regReq.addr == ADDR_EVENT_FLAGS);
    assign hitCtrlOut = (regReq.addr == ADDR_CTRL_OUT);
    // Each index reaches only its own instance
    assign hitPin = inWindow(regReq.addr, ADDR_PIN_BASE,
                             PIN_COUNT); // RULE_17
    assign hitSw = inWindow(regReq.addr, ADDR_SW_BASE,
                            SW_COUNT); // RULE_17
    assign pinIdx = pinOff[2:0];
    assign swIdx = swOff[1:0];

    // ****************************************************************
    // Input synchronizer
    // ****************************************************************
    // Pins only; switch gates and control outputs have no input path
    always_ff @(posedge core_clk) begin
        if (reset) begin
            syncA_r <= '0;
            syncB_r <= '0;
        end else begin
            syncA_r <= pinIn; // RULE_23
            syncB_r <= syncA_r; // RULE_02
        end
    end

    // ****************************************************************
    // Debounce
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi++) begin : g_dbnc
            gsob_dbnc_e effSel;
            // Filter only applies while the pin is an input
            always_comb begin
                if (pinCtrl_r[gi].dirIn) begin
                    effSel = pinCtrl_r[gi].debounce; // RULE_14
                end else begin
                    effSel = DBNC_NONE;
                end
            end
            gsob_debounce #(
                .STEP_CYC(DBNC_STEP)
            ) u_dbnc (
                .core_clk(core_clk),
                .reset(reset),
                .syncIn(syncB_r[gi]),
                .sel(effSel),
                .filtered(filtered[gi])
            );
        end
    endgenerate

    // ****************************************************************
    // Edge detection
    // ****************************************************************
    // Edges come from the filtered level, so a bouncing pin sets a
    // flag only once per accepted change
    always_ff @(posedge core_clk) begin
        if (reset) begin
            prevFilt_r <= '0;
        end else begin
            prevFilt_r <= filtered; // RULE_22
        end
    end

    logic [PIN_COUNT-1:0] riseSeen;
    logic [PIN_COUNT-1:0] fallSeen;

    assign riseSeen = filtered & ~prevFilt_r;
    assign fallSeen = ~filtered & prevFilt_r;

    // Output pins never flag, whatever the edge field holds
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            edgeSet[i] = pinCtrl_r[i].dirIn &&
                         edgeHit(pinCtrl_r[i].edgeSel, riseSeen[i],
                                 fallSeen[i]); // RULE_11
        end
    end

    // ****************************************************************
    // Event flags
    // ****************************************************************
    // Writing ones to the flag address clears them; a new edge in the
    // same cycle wins so no event is lost
    always_comb begin
        flags_nxt = flags_r;
        if (regReq.wrEn && hitFlags) begin
            flags_nxt = flags_nxt & ~regReq.wrData;
        end
        flags_nxt = flags_nxt | edgeSet; // RULE_12
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            flags_r <= FLAGS_RESET; // RULE_15
        end else begin
            flags_r <= flags_nxt; // RULE_13
        end
    end

    // One pulse to the first-level controller per cycle with any new event; edges on several pins in one cycle give one pulse
    always_ff @(posedge core_clk) begin
        if (reset) begin
            summary_r <= 1'b0;
        end else begin
            summary_r <= |edgeSet; // RULE_13
        end
    end

    // ****************************************************************
    // Pin control registers
    // ****************************************************************
    // Level bit is not stored; it is sampled at read time
    always_ff @(posedge core_clk) begin
        if (reset) begin
            for (int i = 0; i < PIN_COUNT; i++) begin
                pinCtrl_r[i] <= gsob_pin_ctrl_s'(PIN_CTRL_RESET); // RULE_04
            end
        end else if (regReq.wrEn && hitPin) begin
            pinCtrl_r[pinIdx] <= gsob_pin_ctrl_s'(regReq.wrData); // RULE_05
            pinCtrl_r[pinIdx].inLevel <= 1'b0;
        end
    end

    // ****************************************************************
    // Switch gate control registers
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (reset) begin
            for (int i = 0; i < SW_COUNT; i++) begin
                swCtrl_r[i] <= gsob_sw_ctrl_s'(SW_CTRL_RESET); // RULE_21
            end
        end else if (regReq.wrEn && hitSw) begin
            swCtrl_r[swIdx] <= gsob_sw_ctrl_s'(regReq.wrData); // RULE_05
            swCtrl_r[swIdx].rsvd <= 2'b00;
        end
    end

    // ****************************************************************
    // Control output register
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrlVal_r <= CTRL_OUT_RESET; // RULE_04
        end else if (regReq.wrEn && hitCtrlOut) begin
            ctrlVal_r <= regReq.wrData; // RULE_01
        end
    end

    // ****************************************************************
    // Pin drivers
    // ****************************************************************
    // Output value is held while an input and appears on turnaround
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pinOut_r <= '0;
        end else begin
            for (int i = 0; i < PIN_COUNT; i++) begin
                pinOut_r[i] <= pinCtrl_r[i].outVal; // RULE_09
            end
        end
    end

    // Open-drain high is a release, so the enable drops
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pinOe_r <= '0; // RULE_04
        end else begin
            for (int i = 0; i < PIN_COUNT; i++) begin
                pinOe_r[i] <= ~pinCtrl_r[i].dirIn &&
                              driveEnable(pinCtrl_r[i].pushPull,
                                          pinCtrl_r[i].outVal); // RULE_07
            end
        end
    end

    // ****************************************************************
    // Switch gate drivers
    // ****************************************************************
    // Gate value reaches the pad two cycles after the write
    always_ff @(posedge core_clk) begin
        if (reset) begin
            swOut_r <= '0;
        end else begin
            for (int i = 0; i < SW_COUNT; i++) begin
                swOut_r[i] <= swCtrl_r[i].outVal; // RULE_20
            end
        end
    end

    // Reset leaves every gate pulling its net low, open-drain
    always_ff @(posedge core_clk) begin
        if (reset) begin
            swOe_r <= '1; // RULE_04
        end else begin
            for (int i = 0; i < SW_COUNT; i++) begin
                swOe_r[i] <= driveEnable(swCtrl_r[i].pushPull,
                                         swCtrl_r[i].outVal); // RULE_19
            end
        end
    end

    // Slew select goes to the pad; scratch bits go nowhere
    always_ff @(posedge core_clk) begin
        if (reset) begin
            swSlew_r <= '0;
        end else begin
            for (int i = 0; i < SW_COUNT; i++) begin
                swSlew_r[2*i +: 2] <= swCtrl_r[i].slew; // RULE_03
            end
        end
    end

    // ****************************************************************
    // Control output drivers
    // ****************************************************************
    // Always driven push-pull, so no enable is brought out
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrlOut_r <= CTRL_OUT_RESET;
        end else begin
            ctrlOut_r <= ctrlVal_r; // RULE_03
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    logic [DATA_W-1:0] rdMux;

    // Pin level bit is the filtered input at the read strobe
    always_comb begin
        rdMux = UNMAPPED_READ;
        if (hitFlags) begin
            rdMux = flags_r; // RULE_15
        end else if (hitPin) begin
            rdMux = {pinCtrl_r[pinIdx][7:3],
                     filtered[pinIdx],
                     pinCtrl_r[pinIdx][1:0]}; // RULE_08
        end else if (hitSw) begin
            rdMux = swCtrl_r[swIdx];
        end else if (hitCtrlOut) begin
            rdMux = ctrlVal_r;
        end
    end

    // One valid pulse per read strobe
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rdValid_r <= 1'b0;
        end else begin
            rdValid_r <= regReq.rdEn;
        end
    end

    // Data is captured in the read cycle and shown one cycle later
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rdData_r <= UNMAPPED_READ;
        end else if (regReq.rdEn) begin
            rdData_r <= rdMux;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign pinOut = pinOut_r; // RULE_10
    assign pinOe = pinOe_r; // RULE_06
    assign swOut = swOut_r;
    assign swOe = swOe_r;
    assign swSlew = swSlew_r;
    assign ctrlOut = ctrlOut_r;
    assign summaryIrqSet = summary_r;
    assign regRsp.rdData = rdData_r;
    assign regRsp.rdValid = rdValid_r;

endmodule

// File: gsob_bank_chk.sv
// Port-level assertions for the pin bank
`timescale 1ns/1ps
module gsob_bank_chk (
    input wire logic core_clk,
    input wire logic reset,
    input wire gsob_pkg::gsob_reg_req_s regReq,
    input wire gsob_pkg::gsob_reg_rsp_s regRsp,
    input wire logic [gsob_pkg::PIN_COUNT-1:0] pinIn,
    input wire logic [gsob_pkg::PIN_COUNT-1:0] pinOut,
    input wire logic [gsob_pkg::PIN_COUNT-1:0] pinOe,
    input wire logic [gsob_pkg::SW_COUNT-1:0] swOut,
    input wire logic [gsob_pkg::SW_COUNT-1:0] swOe,
    input wire logic [2*gsob_pkg::SW_COUNT-1:0] swSlew,
    input wire logic [gsob_pkg::CTRL_COUNT-1:0] ctrlOut,
    input wire logic summaryIrqSet
);
    import gsob_pkg::*;
    // ****************
    // Decode
    // ****************
    wire logic [8:0] a = regReq.addr;
    wire logic [7:0] d = regReq.wrData;
    wire logic pinWr = regReq.wrEn && a[8:3] == 6'h1E;
    wire logic swWr = regReq.wrEn && a[8:2] == 7'h3E;
    wire logic ctlWr = regReq.wrEn && a == ADDR_CTRL_OUT;
    wire logic mapped = a == ADDR_EVENT_FLAGS || a[8:3] == 6'h1E ||
        a[8:2] == 7'h3E || a == ADDR_CTRL_OUT;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    // ****************
    // Properties
    // ****************
    rd_valid_a: assert property (regReq.rdEn |=> regRsp.rdValid)
        else $error("read not answered next cycle");
    rd_hold_a: assert property (!regRsp.rdValid |->
        regRsp.rdData == $past(regRsp.rdData))
        else $error("read data changed without a read");
    rd_unmapped_a: assert property (
        regReq.rdEn && !mapped |=> regRsp.rdData == 8'h00)
        else $error("unmapped read not zero");
    pin_drive_a: assert property (
        pinWr ##1 !pinWr |=> pinOe[$past(a[2:0], 2)] ==
        (!$past(d[1], 2) && ($past(d[0], 2) || !$past(d[3], 2))))
        else $error("pin drive enable wrong");
    pin_value_a: assert property (
        pinWr ##1 !pinWr |=> pinOut[$past(a[2:0], 2)] == $past(d[3], 2))
        else $error("pin output value wrong");
    sw_drive_a: assert property (
        swWr ##1 !swWr |=> swOut[$past(a[1:0], 2)] == $past(d[3], 2) &&
        swOe[$past(a[1:0], 2)] == ($past(d[0], 2) || !$past(d[3], 2)) &&
        swSlew[2*$past(a[1:0], 2) +: 2] == $past(d[5:4], 2))
        else $error("switch gate output wrong");
    ctrl_out_a: assert property (
        ctlWr ##1 !ctlWr |=> ctrlOut == $past(d, 2))
        else $error("control outputs wrong");
    reset_state_a: assert property (disable iff (1'b0)
        reset |=> pinOe == 8'h00 && swOe == 4'hF && swOut == 4'h0 &&
        ctrlOut == 8'h00 && !summaryIrqSet && !regRsp.rdValid)
        else $error("reset output state wrong");
endmodule
bind gsob_bank gsob_bank_chk gsob_bank_chk_inst (.core_clk, .reset,
    .regReq, .regRsp, .pinIn, .pinOut, .pinOe, .swOut, .swOe, .swSlew,
    .ctrlOut, .summaryIrqSet);

// File: gsob_bank_tb.sv
// Self-checking bench for the pin bank
`timescale 1ns/1ps
module gsob_bank_tb;
    import gsob_pkg::*;
    // Short debounce step keeps the 10/20/30 ms cases at 8, 16 and 24 cycles
    localparam logic [DBNC_CNT_W-1:0] STEP = 24'h000008;
    logic core_clk;
    logic reset;
    gsob_reg_req_s regReq;
    gsob_reg_rsp_s regRsp;
    logic [7:0] pinIn, pinOut, pinOe, senseLvl, ctrlOut, swSlew;
    logic [3:0] swOut, swOe, swLevel;
    logic summaryIrqSet;
    int n_errors, checks_done, irqCount, irqBase;
    logic [7:0] pinCfg [6] = '{8'h00, 8'h08, 8'h09, 8'h01, 8'h0A, 8'h02};
    logic [7:0] swCfg [4] = '{8'hFF, 8'h8E, 8'h60, 8'h11};
    logic [7:0] c;
    gsob_bank #(.DBNC_STEP(STEP)) gsob_bank_inst (.core_clk(core_clk),
        .reset(reset), .regReq(regReq), .regRsp(regRsp), .pinIn(pinIn),
        .pinOut(pinOut), .pinOe(pinOe), .swOut(swOut), .swOe(swOe),
        .swSlew(swSlew), .ctrlOut(ctrlOut), .summaryIrqSet(summaryIrqSet));
    gsob_platform gsob_platform_inst (.pinOut(pinOut), .pinOe(pinOe),
        .senseLvl(senseLvl), .swOut(swOut), .swOe(swOe), .pinIn(pinIn),
        .swLevel(swLevel));
    // ****************
    // Clock, tasks
    // ****************
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (summaryIrqSet === 1'b1) irqCount++;
    end
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input string w, input logic [7:0] e,
                       input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] dv);
        regReq.addr = a;
        regReq.wrData = dv;
        regReq.wrEn = 1'b1;
        step(1);
        regReq.wrEn = 1'b0;
        step(1);
    endtask
    task automatic rdChk(input string w, input logic [8:0] a,
                         input logic [7:0] e, input logic [7:0] m);
        regReq.addr = a;
        regReq.rdEn = 1'b1;
        step(1);
        regReq.rdEn = 1'b0;
        chk("rdValid", 8'h01, {7'h00, regRsp.rdValid});
        chk(w, e & m, regRsp.rdData & m);
        step(1);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #(25 * 20000);
        n_errors++;
        tally_and_finish();
    end
    initial begin
        reset = 1'b1;
        regReq = '0;
        senseLvl = 8'h00;
        n_errors = 0;
        checks_done = 0;
        step(2);
        reset = 1'b0;
        chk("pinOe", 8'h00, pinOe);
        chk("swOe", 8'h0F, {4'h0, swOe});
        chk("swOut", 8'h00, {4'h0, swOut});
        chk("ctrlOut", 8'h00, ctrlOut);
        rdChk("flags", ADDR_EVENT_FLAGS, 8'h00, 8'hFF);
        rdChk("ctrl reg", ADDR_CTRL_OUT, 8'h00, 8'hFF);
        for (int i = 0; i < 4; i++) begin
            rdChk("sw reg", ADDR_SW_BASE + 9'(i), 8'h00, 8'hFF);
        end
        wr(9'h0EF, 8'hFF);
        rdChk("unmapped", 9'h0EF, 8'h00, 8'hFF);
        // Every pin runs every driver mode; bit 2 is masked on readback
        for (int i = 0; i < 8; i++) begin
            rdChk("pin reg", ADDR_PIN_BASE + 9'(i), 8'h02, 8'hFF);
            foreach (pinCfg[k]) begin
                c = pinCfg[k];
                wr(ADDR_PIN_BASE + 9'(i), c);
                chk("pinOe", {7'h00, !c[1] && (c[0] || !c[3])},
                    {7'h00, pinOe[i]});
                chk("pinOut", {7'h00, c[3]}, {7'h00, pinOut[i]});
                rdChk("pin reg", ADDR_PIN_BASE + 9'(i), c, 8'hFB);
            end
        end
        for (int i = 0; i < 4; i++) begin
            foreach (swCfg[k]) begin
                c = swCfg[k];
                wr(ADDR_SW_BASE + 9'(i), c);
                chk("swOe", 8'(c[0] || !c[3]), 8'(swOe[i]));
                chk("swLevel", {7'h00, c[3]}, {7'h00, swLevel[i]});
                chk("swSlew", 8'(c[5:4]), 8'(swSlew[2*i +: 2]));
                rdChk("sw reg", ADDR_SW_BASE + 9'(i), c & 8'hF9,
                      8'hFF);
            end
        end
        wr(ADDR_CTRL_OUT, 8'hA5);
        chk("ctrlOut", 8'hA5, ctrlOut);
        rdChk("ctrl reg", ADDR_CTRL_OUT, 8'hA5, 8'hFF);
        // Each pin, each edge mode: mode first, then clear, then edges
        for (int i = 0; i < 8; i++) begin
            for (int m = 0; m < 4; m++) begin
                wr(ADDR_PIN_BASE + 9'(i), {2'b00, 2'(m), 4'h2});
                wr(ADDR_EVENT_FLAGS, 8'hFF);
                irqBase = irqCount;
                senseLvl[i] = 1'b1;
                step(8);
                rdChk("level", ADDR_PIN_BASE + 9'(i), 8'h04, 8'h04);
                rdChk("rise flag", ADDR_EVENT_FLAGS,
                      m[1] ? 8'(1 << i) : 8'h00, 8'hFF);
                wr(ADDR_EVENT_FLAGS, 8'hFF);
                senseLvl[i] = 1'b0;
                step(8);
                rdChk("fall flag", ADDR_EVENT_FLAGS,
                      m[0] ? 8'(1 << i) : 8'h00, 8'hFF);
                chk("irqs", m == 3 ? 8'h02 : 8'(m != 0),
                    8'(irqCount - irqBase));
            end
        end
        // Glitch just shorter than the interval is dropped, steady is kept
        for (int s = 1; s < 4; s++) begin
            wr(ADDR_PIN_BASE, {2'(s), 2'b10, 4'h2});
            wr(ADDR_EVENT_FLAGS, 8'hFF);
            senseLvl[0] = 1'b1;
            step(s * 8 - 3);
            senseLvl[0] = 1'b0;
            step(s * 8 + 8);
            rdChk("glitch", ADDR_EVENT_FLAGS, 8'h00, 8'hFF);
            senseLvl[0] = 1'b1;
            step(s * 8 + 8);
            rdChk("steady", ADDR_EVENT_FLAGS, 8'h01, 8'hFF);
            senseLvl[0] = 1'b0;
            step(s * 8 + 8);
        end
        tally_and_finish();
    end
endmodule

// File: gsob_debounce.sv
// Debounce filter for one synchronized pin input
`timescale 1ns/1ps
module gsob_debounce #(
    parameter logic [gsob_pkg::DBNC_CNT_W-1:0] STEP_CYC =
        gsob_pkg::DBNC_STEP_CYC
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic syncIn,
    input wire gsob_pkg::gsob_dbnc_e sel,
    output logic filtered
);
    import gsob_pkg::*;

    logic [DBNC_CNT_W-1:0] count_r;
    logic filt_r;
    logic [DBNC_CNT_W-1:0] limit;

    assign limit = STEP_CYC * {{(DBNC_CNT_W-2){1'b0}}, sel};
    assign filtered = filt_r;

    // Level must hold for the whole interval before it is accepted
    always_ff @(posedge core_clk) begin
        if (reset) begin
            count_r <= '0;
            filt_r <= 1'b0;
        end else if (sel == DBNC_NONE || syncIn == filt_r) begin
            count_r <= '0;
            if (sel == DBNC_NONE) begin
                filt_r <= syncIn; // RULE_14
            end
        end else if (count_r >= limit - 1'b1) begin
            count_r <= '0;
            filt_r <= syncIn; // RULE_16
        end else begin
            count_r <= count_r + 1'b1; // RULE_16
        end
    end

endmodule

// File: gsob_pkg.sv
// Constants, types and helpers shared by the pin bank and its debouncers
// What this block does
// RULE_01: Eight two-way pins, four switch gates, eight control outputs, each independent.
// RULE_02: Only the two-way pins have an input path and input sampling.
// RULE_03: Control outputs push-pull only; pins and switch gates offer both driver types.
// RULE_04: Reset: pins input high-Z, switch gates open-drain low, control outputs low.
// RULE_05: Each two-way pin and switch gate has one 8-bit control register.
// RULE_06: Pin bit 0 picks driver type: 0 open-drain, 1 push-pull.
// RULE_07: Pin bit 1 picks direction: 0 output, 1 input ignoring bit 0.
// RULE_08: Pin bit 2 reads the pin level captured at read start.
// RULE_09: Pin bit 3 holds output value; kept while input, applied when output.
// RULE_10: Value 0 drives low; 1 drives high push-pull or releases open-drain.
// RULE_11: Pin bits 5:4 select edge detect: mask, falling, rising, both.
// RULE_12: With detect field 00 no transition sets the pin flag.
// RULE_13: A selected edge sets the pin flag and the summary interrupt bit.
// RULE_14: Pin bits 7:6 select debounce: none, 10, 20 or 30 ms.
// RULE_15: Read-only flag register at 0xE8, reset 0x00, bit n for pin n; the code clears the bits written with ones at 0xE8.
// RULE_16: Inputs are filtered over milliseconds so only clean changes are seen.
// RULE_17: Pins indexed 0 to 7, switch gates 0 to 3, each own register.
// RULE_18: Software sets new detect mode, clears interrupts, then unmasks.
// RULE_19: Switch gate bit 0 picks driver type: 0 open-drain, 1 push-pull.
// RULE_20: Switch gate bit 3 sets value: 0 low, 1 high or released.
// RULE_21: Switch gate bits 7:6 are scratch storage, cleared at reset.
// RULE_22: Edges are taken from the debounced, or raw synchronized, input only.
// RULE_23: Pin inputs pass a two-stage synchronizer before any use.
package gsob_pkg;

    localparam int PIN_COUNT = 8;
    localparam int SW_COUNT = 4;
    localparam int CTRL_COUNT = 8;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;
    localparam int DBNC_CNT_W = 24;

    // Register map
    localparam logic [ADDR_W-1:0] ADDR_EVENT_FLAGS = 9'h0E8;
    localparam logic [ADDR_W-1:0] ADDR_PIN_BASE = 9'h0F0;
    localparam logic [ADDR_W-1:0] ADDR_SW_BASE = 9'h0F8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL_OUT = 9'h0FC;

    // Reset values
    localparam logic [DATA_W-1:0] PIN_CTRL_RESET = 8'h02;
    localparam logic [DATA_W-1:0] SW_CTRL_RESET = 8'h00;
    localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h00;
    localparam logic [DATA_W-1:0] CTRL_OUT_RESET = 8'h00;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

    // Debounce timing
    localparam longint CLK_HZ = 40000000;
    localparam longint DBNC_STEP_MS = 10;
    localparam longint DBNC_STEP_CYC_L = CLK_HZ / 1000 * DBNC_STEP_MS;
    localparam logic [DBNC_CNT_W-1:0] DBNC_STEP_CYC =
        DBNC_STEP_CYC_L[DBNC_CNT_W-1:0];

    typedef enum logic [1:0] {
        EDGE_MASK = 2'b00,
        EDGE_FALL = 2'b01,
        EDGE_RISE = 2'b10,
        EDGE_BOTH = 2'b11
    } gsob_edge_e;

    typedef enum logic [1:0] {
        DBNC_NONE = 2'b00,
        DBNC_10MS = 2'b01,
        DBNC_20MS = 2'b10,
        DBNC_30MS = 2'b11
    } gsob_dbnc_e;

    // Field layout of a pin control register, bit 7 first
    typedef struct packed {
        gsob_dbnc_e debounce;
        gsob_edge_e edgeSel;
        logic outVal;
        logic inLevel;
        logic dirIn;
        logic pushPull;
    } gsob_pin_ctrl_s;

    // Field layout of a switch gate control register, bit 7 first
    typedef struct packed {
        logic [1:0] scratch;
        logic [1:0] slew;
        logic outVal;
        logic [1:0] rsvd;
        logic pushPull;
    } gsob_sw_ctrl_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic wrEn;
        logic rdEn;
        logic [DATA_W-1:0] wrData;
    } gsob_reg_req_s;

    typedef struct packed {
        logic [DATA_W-1:0] rdData;
        logic rdValid;
    } gsob_reg_rsp_s;

    // Pad driver enable for a value and driver type
    function automatic logic driveEnable(logic pushPull, logic value);
        return pushPull | ~value;
    endfunction

    function automatic logic edgeHit(gsob_edge_e sel, logic rise,
                                     logic fall);
        logic hit;
        hit = 1'b0;
        unique case (sel)
            EDGE_MASK: hit = 1'b0;
            EDGE_FALL: hit = fall;
            EDGE_RISE: hit = rise;
            EDGE_BOTH: hit = rise | fall;
        endcase
        return hit;
    endfunction

endpackage

// File: gsob_platform.sv
// Platform model: sensing lines and pulled-up switch gate nets
`timescale 1ns/1ps
module gsob_platform (
    input wire logic [gsob_pkg::PIN_COUNT-1:0] pinOut,
    input wire logic [gsob_pkg::PIN_COUNT-1:0] pinOe,
    input wire logic [gsob_pkg::PIN_COUNT-1:0] senseLvl,
    input wire logic [gsob_pkg::SW_COUNT-1:0] swOut,
    input wire logic [gsob_pkg::SW_COUNT-1:0] swOe,
    output logic [gsob_pkg::PIN_COUNT-1:0] pinIn,
    output logic [gsob_pkg::SW_COUNT-1:0] swLevel
);
    import gsob_pkg::*;
    // ****************
    // Wire levels
    // ****************
    // Driven pin wins over the sensor; a fight would be a board fault
    assign pinIn = (pinOe & pinOut) | (~pinOe & senseLvl);
    // Released gate nets float up through the external pull-up
    assign swLevel = (swOe & swOut) | ~swOe;
endmodule
